// [inc/psd_pkg.sv]
// Package for the pad state and strap detect block.
// Assumes a single 40 MHz core clock; all pins sampled synchronously.
package psd_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_MHZ        = 40;
  localparam int STRAP_SETTLE_US = 1;
  localparam int STRAP_CYCLES   = STRAP_SETTLE_US * CLK_MHZ;

  // ==========================================================================
  // Host transport, one-hot
  typedef enum logic [3:0] {
    PSD_TP_NONE = 4'h1,
    PSD_TP_UART = 4'h2,
    PSD_TP_SDIO = 4'h4,
    PSD_TP_SPI  = 4'h8
  } psd_tport_e;

  // Strap sequencer, one-hot
  typedef enum logic [2:0] {
    PSD_ST_SETTLE = 3'h1,
    PSD_ST_EEPROM = 3'h2,
    PSD_ST_RUN    = 3'h4
  } psd_strap_e;

  // Boundary-scan select tracking, one-hot
  typedef enum logic [2:0] {
    PSD_SC_WAIT_RISE = 3'h1,
    PSD_SC_WAIT_FALL = 3'h2,
    PSD_SC_DONE      = 3'h4
  } psd_scan_e;

  // Pull codes
  localparam logic [1:0] PULL_NONE = 2'h0;
  localparam logic [1:0] PULL_UP   = 2'h1;
  localparam logic [1:0] PULL_DOWN = 2'h2;

  // Per-pad control: output enable is active low
  typedef struct packed {
    logic       out_en_n;
    logic       out_val;
    logic [1:0] pull;
  } psd_pad_s;

  localparam psd_pad_s PAD_RESET = '{out_en_n: 1'b1, out_val: 1'b0,
                                     pull: PULL_DOWN};

endpackage

// [rtl/psd_top.sv]
// Pad control, transport pin mux and strap detection for the host pins.
// Assumes the host pad inputs are synchronous to clk_sys; rst_b is the
// active-low power-on reset; shutdown comes from the separate shutdown_req input.
`timescale 1ns/100ps
module psd_top (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  // Core-side controls
  input  wire logic        shutdown_req,
  input  wire logic        clock_share_sel,
  input  wire logic        clock_request,
  input  wire logic        req_pin_as_gp,
  input  wire logic        gp0_out,
  input  wire logic        pcm_master,
  input  wire logic        pcm_sync_out,
  input  wire logic        pcm_clk_out,
  input  wire logic        first_byte_seen,
  input  wire logic [1:0]  detected_transport,
  input  wire logic        host_tx_val,
  input  wire logic        host_irq_val,
  input  wire logic        eeprom_done,
  input  wire logic        eeprom_scl_val,
  input  wire logic        eeprom_sda_val,
  input  wire logic        scan_tdo_val,
  // Pad inputs
  input  wire logic        scan_tck_in,
  input  wire logic        scan_tdo_in,
  input  wire logic        eeprom_clock_strap_in,
  input  wire logic        host_rx_cmd_in,
  input  wire logic        host_clear_select_in,
  input  wire logic        host_card_clock_in,
  // Pad controls
  output psd_pkg::psd_pad_s host_rx_cmd_pad,
  output psd_pkg::psd_pad_s host_tx_data_pad,
  output psd_pkg::psd_pad_s host_request_irq_pad,
  output psd_pkg::psd_pad_s host_clear_select_pad,
  output psd_pkg::psd_pad_s host_card_clock_pad,
  output psd_pkg::psd_pad_s pcm_frame_sync_pad,
  output psd_pkg::psd_pad_s pcm_bit_clock_pad,
  output psd_pkg::psd_pad_s eeprom_clock_strap_pad,
  output psd_pkg::psd_pad_s eeprom_data_pad,
  output psd_pkg::psd_pad_s clock_request_output_pad,
  output psd_pkg::psd_pad_s clock_request_input_pad,
  output psd_pkg::psd_pad_s scan_tdo_pad,
  output psd_pkg::psd_pad_s gp_pin_sixteen_pad,
  output psd_pkg::psd_pad_s debug_uart_out_pad,
  // Status
  output logic             boundary_scan_mode,
  output logic             eeprom_fetch_active,
  output logic [3:0]       transport_state,
  output logic             host_rx_cmd_core,
  output logic             host_clear_select_core,
  output logic             host_card_clock_core
);

  // ==========================================================================
  // Reset release
  logic rst_meta_reg;
  logic rst_sync_reg;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // ==========================================================================
  // Input synchronisers for test clock, scan-out and strap
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic       tck_prev_reg;

  always_ff @(posedge clk_sys or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      sync1_reg    <= 3'h0;
      sync2_reg    <= 3'h0;
      tck_prev_reg <= 1'b0;
    end else begin
      sync1_reg    <= {scan_tck_in, scan_tdo_in, eeprom_clock_strap_in};
      sync2_reg    <= sync1_reg;
      tck_prev_reg <= sync2_reg[2];
    end
  end

  logic tck_rise;
  logic tck_fall;
  assign tck_rise = sync2_reg[2] & ~tck_prev_reg;
  assign tck_fall = ~sync2_reg[2] & tck_prev_reg;

  // ==========================================================================
  // Boundary-scan select
  psd_pkg::psd_scan_e scan_reg;
  psd_pkg::psd_scan_e scan_next;
  logic               bscan_reg;
  logic               bscan_next;

  always_comb begin
    scan_next  = scan_reg;
    bscan_next = bscan_reg;
    unique case (scan_reg)
      psd_pkg::PSD_SC_WAIT_RISE: begin
        if (tck_rise) begin
          bscan_next = ~sync2_reg[1];
          scan_next  = psd_pkg::PSD_SC_WAIT_FALL;
        end
      end
      psd_pkg::PSD_SC_WAIT_FALL: begin
        if (tck_fall) begin
          scan_next = psd_pkg::PSD_SC_DONE;
        end
      end
      psd_pkg::PSD_SC_DONE: begin
        scan_next = psd_pkg::PSD_SC_DONE;
      end
      default: begin
        scan_next = psd_pkg::PSD_SC_WAIT_RISE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      scan_reg  <= psd_pkg::PSD_SC_WAIT_RISE;
      bscan_reg <= 1'b0;
    end else begin
      scan_reg  <= scan_next;
      bscan_reg <= bscan_next;
    end
  end

  // ==========================================================================
  // Power-up strap and EEPROM fetch window
  // The strap is only honoured after a settle count so a slow pulldown
  // on an open pin has time to win.
  localparam logic [7:0] SETTLE_LAST = 8'(psd_pkg::STRAP_CYCLES - 1);

  psd_pkg::psd_strap_e strap_reg;
  psd_pkg::psd_strap_e strap_next;
  logic [7:0]          settle_reg;
  logic [7:0]          settle_next;

  always_comb begin
    strap_next  = strap_reg;
    settle_next = settle_reg;
    unique case (strap_reg)
      psd_pkg::PSD_ST_SETTLE: begin
        if (settle_reg == SETTLE_LAST) begin
          if (sync2_reg[0]) begin
            strap_next = psd_pkg::PSD_ST_EEPROM;
          end else begin
            strap_next = psd_pkg::PSD_ST_RUN;
          end
        end else begin
          settle_next = settle_reg + 8'h01;
        end
      end
      psd_pkg::PSD_ST_EEPROM: begin
        if (eeprom_done) begin
          strap_next = psd_pkg::PSD_ST_RUN;
        end
      end
      psd_pkg::PSD_ST_RUN: begin
        strap_next = psd_pkg::PSD_ST_RUN;
      end
      default: begin
        strap_next = psd_pkg::PSD_ST_SETTLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      strap_reg  <= psd_pkg::PSD_ST_SETTLE;
      settle_reg <= 8'h00;
    end else begin
      strap_reg  <= strap_next;
      settle_reg <= settle_next;
    end
  end

  // ==========================================================================
  // Transport detection, latched on the first received byte
  psd_pkg::psd_tport_e tport_reg;
  psd_pkg::psd_tport_e tport_next;

  always_comb begin
    tport_next = tport_reg;
    if (tport_reg == psd_pkg::PSD_TP_NONE && first_byte_seen) begin
      unique case (detected_transport)
        2'h1:    tport_next = psd_pkg::PSD_TP_SDIO;
        2'h2:    tport_next = psd_pkg::PSD_TP_SPI;
        default: tport_next = psd_pkg::PSD_TP_UART;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      tport_reg <= psd_pkg::PSD_TP_NONE;
    end else begin
      tport_reg <= tport_next;
    end
  end

  // ==========================================================================
  // Pad state computation
  psd_pkg::psd_pad_s [13:0] pad_next;
  psd_pkg::psd_pad_s [13:0] pad_reg;
  logic [2:0]               core_next;
  logic [2:0]               core_reg;

  localparam psd_pkg::psd_pad_s Z_UP   = '{1'b1, 1'b0, psd_pkg::PULL_UP};
  localparam psd_pkg::psd_pad_s Z_DOWN = '{1'b1, 1'b0, psd_pkg::PULL_DOWN};
  localparam psd_pkg::psd_pad_s Z_NONE = '{1'b1, 1'b0, psd_pkg::PULL_NONE};

  logic       card_bus;
  logic [1:0] host_pull;
  logic       in_shut;
  logic       fetching;

  always_comb begin
    card_bus = (tport_reg == psd_pkg::PSD_TP_SDIO) ||
               (tport_reg == psd_pkg::PSD_TP_SPI);
    in_shut  = shutdown_req;
    fetching = (strap_reg == psd_pkg::PSD_ST_EEPROM);
    // Pulls stay on until the transport is known; SDIO keeps them
    if (tport_reg == psd_pkg::PSD_TP_NONE ||
        tport_reg == psd_pkg::PSD_TP_SDIO) begin
      host_pull = psd_pkg::PULL_UP;
    end else begin
      host_pull = psd_pkg::PULL_NONE;
    end

    // Host pins: rx/cmd, tx/data, request/irq, clear/select
    pad_next[0] = '{1'b1, 1'b0, host_pull};
    pad_next[1] = '{(tport_reg == psd_pkg::PSD_TP_NONE), host_tx_val,
                    host_pull};
    pad_next[2] = '{(tport_reg == psd_pkg::PSD_TP_NONE), host_irq_val,
                    host_pull};
    pad_next[3] = '{1'b1, 1'b0, host_pull};
    // Card clock pin: input for SDIO/SPI, otherwise a quiet gp pin
    pad_next[4] = card_bus ? Z_NONE : Z_DOWN;
    // PCM pins
    pad_next[5] = '{~pcm_master, pcm_sync_out, psd_pkg::PULL_DOWN};
    pad_next[6] = '{~pcm_master, pcm_clk_out, psd_pkg::PULL_DOWN};
    // EEPROM strap and data
    if (fetching) begin
      pad_next[7] = '{1'b0, eeprom_scl_val, psd_pkg::PULL_NONE};
      pad_next[8] = '{1'b0, eeprom_sda_val, psd_pkg::PULL_UP};
    end else begin
      pad_next[7] = Z_DOWN;
      pad_next[8] = Z_UP;
    end
    // Clock request pins
    if (!clock_share_sel) begin
      pad_next[9]  = Z_NONE;
      pad_next[10] = Z_NONE;
    end else begin
      pad_next[9]  = '{1'b0, req_pin_as_gp ? gp0_out : clock_request,
                       psd_pkg::PULL_DOWN};
      pad_next[10] = Z_DOWN;
    end
    // Scan-out: input with pulldown until the first falling test edge, and after it too unless scan mode was selected
    if (scan_reg == psd_pkg::PSD_SC_DONE && bscan_reg) begin
      pad_next[11] = '{1'b0, scan_tdo_val, psd_pkg::PULL_DOWN};
    end else begin
      pad_next[11] = Z_DOWN;
    end
    pad_next[12] = Z_UP;
    pad_next[13] = '{1'b0, 1'b1, psd_pkg::PULL_UP};

    if (in_shut) begin
      pad_next[0]  = Z_UP;
      pad_next[1]  = Z_UP;
      pad_next[2]  = Z_UP;
      pad_next[3]  = Z_UP;
      pad_next[4]  = Z_DOWN;
      pad_next[5]  = Z_DOWN;
      pad_next[6]  = Z_DOWN;
      pad_next[7]  = Z_DOWN;
      pad_next[8]  = Z_UP;
      pad_next[11] = Z_DOWN;
      pad_next[12] = Z_UP;
      pad_next[13] = Z_UP;
      if (clock_share_sel) begin
        pad_next[9].pull = psd_pkg::PULL_NONE;
        pad_next[10]     = Z_DOWN;
      end
    end

    core_next = {host_rx_cmd_in, host_clear_select_in,
                 card_bus & host_card_clock_in};
  end

  always_ff @(posedge clk_sys or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      pad_reg  <= {14{psd_pkg::PAD_RESET}};
      core_reg <= 3'h0;
    end else begin
      pad_reg  <= pad_next;
      core_reg <= core_next;
    end
  end

  // ==========================================================================
  // Outputs
  assign host_rx_cmd_pad          = pad_reg[0];
  assign host_tx_data_pad         = pad_reg[1];
  assign host_request_irq_pad     = pad_reg[2];
  assign host_clear_select_pad    = pad_reg[3];
  assign host_card_clock_pad      = pad_reg[4];
  assign pcm_frame_sync_pad       = pad_reg[5];
  assign pcm_bit_clock_pad        = pad_reg[6];
  assign eeprom_clock_strap_pad   = pad_reg[7];
  assign eeprom_data_pad          = pad_reg[8];
  assign clock_request_output_pad = pad_reg[9];
  assign clock_request_input_pad  = pad_reg[10];
  assign scan_tdo_pad             = pad_reg[11];
  assign gp_pin_sixteen_pad       = pad_reg[12];
  assign debug_uart_out_pad       = pad_reg[13];
  assign boundary_scan_mode       = bscan_reg;
  assign eeprom_fetch_active      = (strap_reg == psd_pkg::PSD_ST_EEPROM);
  assign transport_state          = tport_reg;
  assign host_rx_cmd_core         = core_reg[2];
  assign host_clear_select_core   = core_reg[1];
  assign host_card_clock_core     = core_reg[0];

endmodule

// [tb/psd_chk_assertions.sv]
// Checker on psd_top ports: pad directions, pulls and mode latches.
// Assumes binding to psd_top; clk_sys is the only clock.
`timescale 1ns/100ps
module psd_chk (
  input wire logic              clk_sys,
  input wire logic              rst_b,
  input wire logic              shutdown_req,
  input wire logic              clock_share_sel,
  input wire logic              pcm_master,
  input wire psd_pkg::psd_pad_s host_rx_cmd_pad,
  input wire psd_pkg::psd_pad_s host_tx_data_pad,
  input wire psd_pkg::psd_pad_s pcm_frame_sync_pad,
  input wire psd_pkg::psd_pad_s eeprom_clock_strap_pad,
  input wire psd_pkg::psd_pad_s eeprom_data_pad,
  input wire psd_pkg::psd_pad_s clock_request_output_pad,
  input wire psd_pkg::psd_pad_s clock_request_input_pad,
  input wire psd_pkg::psd_pad_s scan_tdo_pad,
  input wire logic              boundary_scan_mode,
  input wire logic              eeprom_fetch_active,
  input wire logic [3:0]        transport_state
);
  // ==========================================================================
  // Settle counter
  // Pads lag the reset release by a few edges, so pad checks other than chk_tdo_input and chk_fetch_drive wait for it
  logic [3:0] up_reg;
  logic [3:0] up_next;
  logic       ok;
  always_comb up_next = (up_reg == 4'hf) ? up_reg : up_reg + 4'h1;
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b) up_reg <= 4'h0;
    else up_reg <= up_next;
  assign ok = (up_reg == 4'hf);

  // ==========================================================================
  // Assertions
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  chk_tport_onehot: assert property ($onehot(transport_state))
    else $error("transport state not one-hot");
  chk_bscan_latch: assert property (boundary_scan_mode |=>
    boundary_scan_mode) else $error("scan mode dropped");
  chk_tdo_input: assert property (!boundary_scan_mode |->
    scan_tdo_pad.out_en_n) else $error("scan out driven");
  chk_pull_wait: assert property ((ok && transport_state == 4'h1)[*2]
    |-> host_rx_cmd_pad.pull == psd_pkg::PULL_UP)
    else $error("host pull lost before detect");
  chk_pull_sdio: assert property ((ok && transport_state == 4'h4)[*2]
    |-> host_tx_data_pad.pull == psd_pkg::PULL_UP)
    else $error("host pull lost in card mode");
  chk_pull_off: assert property ((ok && !shutdown_req &&
    (transport_state == 4'h2 || transport_state == 4'h8))[*2]
    |-> host_rx_cmd_pad.pull == psd_pkg::PULL_NONE)
    else $error("host pull kept");
  chk_shut_hiz: assert property ((ok && shutdown_req)[*2] |->
    host_rx_cmd_pad.out_en_n && host_tx_data_pad.pull == psd_pkg::PULL_UP)
    else $error("host pad not parked");
  chk_req_keep: assert property ((ok && shutdown_req &&
    clock_share_sel)[*2] |-> !clock_request_output_pad.out_en_n &&
    clock_request_output_pad.pull == psd_pkg::PULL_NONE)
    else $error("request out not kept");
  chk_req_wired: assert property ((ok && !clock_share_sel)[*2] |->
    clock_request_output_pad.out_en_n && clock_request_input_pad.out_en_n)
    else $error("request pins driven");
  chk_pcm_dir: assert property ((ok && !shutdown_req &&
    pcm_master)[*2] |-> !pcm_frame_sync_pad.out_en_n)
    else $error("frame sync not driven");
  chk_fetch_drive: assert property ((eeprom_fetch_active &&
    !shutdown_req)[*2] |-> !eeprom_clock_strap_pad.out_en_n &&
    !eeprom_data_pad.out_en_n) else $error("eeprom pins not driven");
endmodule

bind psd_top psd_chk chk_u (.*);

// [tb/psd_host_model.sv]
// Host processor model: sends one first byte on the host pins.
// Assumes clk_sys; kind 1 card, 2 five-wire, else UART.
`timescale 1ns/100ps
module psd_host_model (
  input  wire logic       clk_sys,
  input  wire logic       send,
  input  wire logic [1:0] kind,
  output logic            host_rx_cmd_in,
  output logic            host_clear_select_in,
  output logic            host_card_clock_in,
  output logic            first_byte_seen,
  output logic [1:0]      detected_transport
);
  logic [7:0] shift;
  logic [3:0] left;
  initial begin
    {host_card_clock_in, first_byte_seen, left, shift} = '0;
    {host_rx_cmd_in, host_clear_select_in} = 2'h3;
    detected_transport = 2'h0;
  end
  // Clock and select move only inside the byte; idle clock sits low, rx/cmd and select high
  always @(posedge clk_sys) begin
    first_byte_seen <= (left == 4'h1);
    detected_transport <= kind;
    if (send) begin
      left <= 4'h9;
      shift <= 8'ha5;
    end else if (left != 4'h0) begin
      left <= left - 4'h1;
      shift <= shift << 1;
    end
    host_rx_cmd_in <= (left > 4'h1) ? shift[7] : 1'b1;
    host_clear_select_in <= !(kind == 2'h2 && left > 4'h1);
    host_card_clock_in <= kind != 2'h0 && left > 4'h1 && !host_card_clock_in;
  end
endmodule

// [tb/test_psd_top.sv]
// Self-checking bench for psd_top with a host-side model.
// Assumes psd_pkg is compiled first; one 40 MHz clock.
`timescale 1ns/100ps
module test_psd_top;
  logic clk_sys, rst_b, shutdown_req, clock_share_sel, clock_request;
  logic req_pin_as_gp, gp0_out, pcm_master, pcm_sync_out, pcm_clk_out;
  logic first_byte_seen, host_tx_val, host_irq_val, eeprom_done, send;
  logic eeprom_scl_val, eeprom_sda_val, scan_tdo_val, scan_tck_in;
  logic scan_tdo_in, eeprom_clock_strap_in, host_rx_cmd_in;
  logic host_clear_select_in, host_card_clock_in, boundary_scan_mode;
  logic eeprom_fetch_active, host_rx_cmd_core, host_clear_select_core;
  logic host_card_clock_core;
  logic [1:0] detected_transport, kind;
  logic [3:0] transport_state;
  logic [31:0] r;
  logic [31:0] seed = 32'he02e;
  psd_pkg::psd_pad_s host_rx_cmd_pad, host_tx_data_pad, host_request_irq_pad;
  psd_pkg::psd_pad_s host_clear_select_pad, host_card_clock_pad;
  psd_pkg::psd_pad_s pcm_frame_sync_pad, pcm_bit_clock_pad, eeprom_data_pad;
  psd_pkg::psd_pad_s eeprom_clock_strap_pad, clock_request_output_pad;
  psd_pkg::psd_pad_s clock_request_input_pad, scan_tdo_pad;
  psd_pkg::psd_pad_s gp_pin_sixteen_pad, debug_uart_out_pad;
  typedef struct {int s; logic [7:0] e; logic [7:0] m;} psd_note_s;
  psd_note_s notes [$];
  psd_note_s n;
  int error_cnt, total_checks, i, k;
  event look;
  logic [1:0] tk [3] = '{2'h1, 2'h2, 2'h0};
  logic [3:0] te [3] = '{4'h4, 4'h8, 4'h2};
  string nm [18] = '{"tport", "bscan", "fetch", "rx_pad", "tx_pad",
                     "strap_pad", "tdo_pad", "req_out", "req_in", "fsync",
                     "irq_pad", "cts_pad", "card_pad", "bclk_pad",
                     "sda_pad", "gp16_pad", "dbg_pad", "core_in"};

  psd_top dut_u (.*);
  psd_host_model host_u (.*);

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // ==========================================================================
  // Helpers
  function automatic logic [7:0] peek(int s);
    case (s)
      0: return {4'h0, transport_state};
      1: return {7'h0, boundary_scan_mode};
      2: return {7'h0, eeprom_fetch_active};
      3: return {4'h0, host_rx_cmd_pad};
      4: return {4'h0, host_tx_data_pad};
      5: return {4'h0, eeprom_clock_strap_pad};
      6: return {4'h0, scan_tdo_pad};
      7: return {4'h0, clock_request_output_pad};
      8: return {4'h0, clock_request_input_pad};
      9: return {4'h0, pcm_frame_sync_pad};
      10: return {4'h0, host_request_irq_pad};
      11: return {4'h0, host_clear_select_pad};
      12: return {4'h0, host_card_clock_pad};
      13: return {4'h0, pcm_bit_clock_pad};
      14: return {4'h0, eeprom_data_pad};
      15: return {4'h0, gp_pin_sixteen_pad};
      16: return {4'h0, debug_uart_out_pad};
      default: return {5'h0, host_rx_cmd_core, host_clear_select_core,
                       host_card_clock_core};
    endcase
  endfunction

  function automatic logic [31:0] xorshift(logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction

  task automatic check(int s, logic [7:0] seen, logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", nm[s], exp, seen);
    end
  endtask

  task automatic note(int s, logic [7:0] e, logic [7:0] m);
    notes.push_back('{s, e, m});
    -> look;
  endtask

  task automatic results();
    if (error_cnt == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Drives always land 2 ns after the edge, never on it
  task automatic tick(int c);
    repeat (c) @(posedge clk_sys);
    #2;
    seed = xorshift(seed);
    r = seed;
    {eeprom_scl_val, eeprom_sda_val, scan_tdo_val, host_irq_val} = r[3:0];
    pcm_clk_out = r[5];
  endtask

  task automatic powerup(logic strap, logic tdo);
    rst_b = 1'b0;
    eeprom_clock_strap_in = strap;
    scan_tdo_in = tdo;
    tick(6);
    rst_b = 1'b1;
    tick(50);
    note(2, {7'h0, strap}, 8'h01);
    note(5, strap ? 8'h00 : 8'h0a, strap ? 8'h08 : 8'h0b);
    note(3, {6'h0, psd_pkg::PULL_UP}, 8'h03);
    note(14, {4'h0, !strap, 1'b0, psd_pkg::PULL_UP}, 8'h0b);
    note(12, {6'h2, psd_pkg::PULL_DOWN}, 8'h0f);
    scan_tck_in = 1'b1;
    tick(6);
    note(1, {7'h0, !tdo}, 8'h01);
    scan_tck_in = 1'b0;
    tick(6);
    note(6, {4'h0, tdo, 3'h0}, 8'h08);
    scan_tdo_in = !tdo;
    scan_tck_in = 1'b1;
    tick(6);
    note(1, {7'h0, !tdo}, 8'h01);
    scan_tck_in = 1'b0;
    scan_tdo_in = tdo;
  endtask

  // ==========================================================================
  // Monitor: oldest note against what the outputs show now
  initial forever begin
    @(look);
    while (notes.size() > 0) begin
      n = notes.pop_front();
      check(n.s, peek(n.s) & n.m, n.e & n.m);
    end
  end

  initial begin
    #400000;
    error_cnt++;
    results();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    {shutdown_req, clock_share_sel, clock_request, req_pin_as_gp} = 4'h0;
    {gp0_out, pcm_master, pcm_sync_out, pcm_clk_out, host_tx_val} = 5'h0;
    {host_irq_val, eeprom_done, eeprom_scl_val, eeprom_sda_val} = 4'h0;
    {scan_tdo_val, scan_tck_in, send, kind} = 5'h0;
    {rst_b, scan_tdo_in, eeprom_clock_strap_in} = 3'h1;
    error_cnt = 0;
    total_checks = 0;
    #20;
    note(3, {4'h0, psd_pkg::PAD_RESET}, 8'h0f);
    note(0, 8'h01, 8'hff);
    powerup(1'b1, 1'b0);
    eeprom_done = 1'b1;
    tick(1);
    eeprom_done = 1'b0;
    tick(4);
    note(2, 8'h00, 8'h01);
    for (k = 0; k < 3; k++) begin
      powerup(1'b0, 1'b1);
      kind = tk[k];
      send = 1'b1;
      tick(1);
      send = 1'b0;
      for (i = 0; i < 40 && first_byte_seen !== 1'b1; i++) tick(1);
      if (first_byte_seen !== 1'b1) begin
        error_cnt++;
        results();
      end
      tick(3);
      note(0, {4'h0, te[k]}, 8'hff);
      note(3, {6'h0, (k == 0) ? psd_pkg::PULL_UP : psd_pkg::PULL_NONE},
           8'h03);
      note(10, 8'h00, 8'h08);
      note(11, {6'h2, (k == 0) ? psd_pkg::PULL_UP : psd_pkg::PULL_NONE},
           8'h0f);
      note(12, {6'h2, (k < 2) ? psd_pkg::PULL_NONE : psd_pkg::PULL_DOWN},
           8'h0f);
      note(17, 8'h06, 8'h07);
      host_tx_val = r[9];
      tick(2);
      if (k == 2) note(4, {5'h0, host_tx_val, 2'h0}, 8'h0c);
    end
    clock_share_sel = 1'b1;
    for (i = 0; i < 3; i++) begin
      req_pin_as_gp = (i == 1);
      shutdown_req = (i == 2);
      clock_request = r[3];
      gp0_out = r[4];
      tick(3);
      note(7, {5'h0, (i == 1) ? gp0_out : clock_request, 2'h0},
           (i == 2) ? 8'h0f : 8'h0c);
    end
    note(3, {6'h2, psd_pkg::PULL_UP}, 8'h0b);
    note(10, {6'h2, psd_pkg::PULL_UP}, 8'h0f);
    note(11, {6'h2, psd_pkg::PULL_UP}, 8'h0f);
    note(12, {6'h2, psd_pkg::PULL_DOWN}, 8'h0f);
    note(13, {6'h2, psd_pkg::PULL_DOWN}, 8'h0f);
    note(14, {6'h2, psd_pkg::PULL_UP}, 8'h0f);
    note(15, {6'h2, psd_pkg::PULL_UP}, 8'h0f);
    note(16, {6'h2, psd_pkg::PULL_UP}, 8'h0f);
    note(8, {6'h2, psd_pkg::PULL_DOWN}, 8'h0f);
    clock_share_sel = 1'b0;
    tick(3);
    note(7, 8'h08, 8'h08);
    note(8, 8'h08, 8'h08);
    shutdown_req = 1'b0;
    for (i = 0; i < 2; i++) begin
      pcm_master = i[0];
      pcm_sync_out = r[7];
      tick(3);
      note(9, {4'h0, !i[0], pcm_sync_out & i[0], 2'h0},
           i[0] ? 8'h0c : 8'h08);
      note(13, {4'h0, !i[0], 3'h0}, 8'h08);
    end
    tick(2);
    results();
  end
endmodule
